// File: src/t0ps_pkg.sv
// Constants, register map and carrier types of the timer0 block with shared prescaler
package t0ps_pkg;

    // Clock and instruction timing
    localparam int unsigned CLK_HZ             = 20_000_000;
    localparam int unsigned CLKS_PER_INSTR     = 4;
    localparam int unsigned INSTR_HZ           = CLK_HZ / CLKS_PER_INSTR;
    localparam logic [1:0]  WRITE_INHIBIT_INSTR = 2'h2;

    // Register indexes; the byte address is four times the index
    localparam logic [7:0]  IDX_COUNT    = 8'h01;
    localparam logic [7:0]  IDX_INTCTL   = 8'h0B;
    localparam logic [7:0]  IDX_OPTION   = 8'h81;
    localparam logic [7:0]  IDX_EVT_STAT = 8'h90;
    localparam logic [7:0]  IDX_EVT_MASK = 8'h91;
    localparam int unsigned ADDR_W       = 10;

    // Values after reset
    localparam logic [7:0]  COUNT_RST    = 8'h00;
    localparam logic [7:0]  INTCTL_RST   = 8'h00;
    localparam logic [7:0]  OPTION_RST   = 8'hFF;
    localparam logic [1:0]  EVT_RST      = 2'h0;

    // Field positions
    localparam int unsigned OPT_SRC_BIT    = 5;
    localparam int unsigned OPT_EDGE_BIT   = 4;
    localparam int unsigned OPT_ASSIGN_BIT = 3;
    localparam int unsigned INT_EN_BIT     = 5;
    localparam int unsigned INT_FLAG_BIT   = 2;
    localparam int unsigned EVT_OVF_BIT    = 0;
    localparam int unsigned EVT_WDT_BIT    = 1;
    localparam int unsigned EVT_W          = 2;

    // Instruction phases, Gray coded along Q1..Q4
    typedef enum logic [1:0] {
        T0PS_Q1 = 2'h0,
        T0PS_Q2 = 2'h1,
        T0PS_Q3 = 2'h3,
        T0PS_Q4 = 2'h2
    } t0ps_phase_t;

    // Option register fields
    typedef struct packed {
        logic [1:0] other;
        logic       count_source_sel;
        logic       count_edge_sel;
        logic       prescaler_assign;
        logic [2:0] prescale_ratio;
    } t0ps_option_t;

    // Whole state of the block
    typedef struct packed {
        t0ps_phase_t   phase;
        logic [7:0]    timer0_count;
        logic [7:0]    interrupt_control;
        t0ps_option_t  option_config;
        logic [7:0]    prescaler;
        logic          tap_prev;
        logic          ext_prev;
        logic [1:0]    inhibit;
        logic          sync_q2;
        logic          sync_q4;
        logic          sync_prev;
        logic [1:0]    evt_status;
        logic [1:0]    evt_mask;
        logic          ack;
        logic [31:0]   rdata;
        logic          wdt_tick;
        logic          wdt_clear;
    } t0ps_state_t;

endpackage : t0ps_pkg

// File: src/t0ps_timer0.sv
// Timer0 counter with prescaler shared with the watchdog, Avalon-MM register slave
`timescale 1ns/100ps
module t0ps_timer0 #(
    parameter int unsigned ADDR_W = t0ps_pkg::ADDR_W
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic [ADDR_W-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic      [31:0]       o_avs_readdata,
    output logic                   o_avs_waitrequest,
    input  wire logic              i_ext_count_input,
    input  wire logic              i_sleep,
    input  wire logic              i_wdt_tick,
    input  wire logic              i_watchdog_clear_instr,
    output logic                   o_wdt_tick,
    output logic                   o_watchdog_clear,
    output logic                   o_overflow_irq,
    output logic                   o_irq
);

    initial begin
        if (ADDR_W < 10 || ADDR_W > 16) begin
            $error("ADDR_W must be 10 to 16");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Programming notes
    //
    // Register map, one 8-bit register per 32-bit word, data in bits 7..0:
    //   index 01h  timer0_count       counter value, read and write
    //   index 0Bh  interrupt_control  bit 5 overflow enable, bit 2 overflow flag
    //   index 81h  option_config      bit 5 source, bit 4 edge, bit 3 assign,
    //                                 bits 2..0 ratio, bits 7..6 plain storage
    //   index 90h  event status       bit 0 overflow, bit 1 watchdog tick
    //   index 91h  event mask         same layout as the event status
    // Byte address is four times the index; misaligned addresses decode as
    // index zero, which reads zero and ignores writes.
    //
    // Bus timing:
    //   Every access takes exactly one wait state, so a transfer is two cycles.
    //   Read data are captured on the first edge of the request and presented
    //   on the accepting edge, so a read returns the state one cycle old.
    //   Side effects (write, status clear) happen on the accepting edge only.
    //   Writes apply only when byte lane zero is enabled.
    //
    // Instruction timing:
    //   The phase sequencer steps Q1..Q4 once per clock; one instruction
    //   cycle is four clocks and ends in Q4. Reset starts the sequencer in Q1.
    //   Counter increments happen on the Q4 clock; a prescaled timer increment lands on the Q1 clock after it.
    //
    // Count sources:
    //   Timer mode counts the end of every instruction cycle, either directly
    //   or through the prescaler when the counter owns it.
    //   Counter mode counts edges of the external pin. The edge bit inverts the
    //   pin so that the counted edge is always a rise inside the block.
    //   The sampler takes its source at Q2 and moves that sample on at Q4; a rise is counted
    //   once per instruction cycle, so the pin must hold each level for at
    //   least one instruction cycle to be seen reliably.
    //
    // Prescaler:
    //   One 8-bit counter, owned by the timer or by the watchdog, never both.
    //   The timer taps stage N and counts its carry out in timer mode and its rise through the sampler in counter mode, giving 2 to 256.
    //   The watchdog taps stage N-1, giving 2 to 128; ratio zero passes the
    //   watchdog tick straight through.
    //   Counting the carry out rather than the rising stage means that a
    //   cleared prescaler gives the full period before the first step in timer mode;
    //   counter mode counts the rising stage, so its first step comes after half of it.
    //   A count write clears it while the timer owns it; the watchdog clear
    //   input clears it while the watchdog owns it. Reassignment alone does
    //   not clear it, so software clears first and then reassigns.
    //   Its count never reaches the read path.
    //
    // Count write:
    //   A write loads the counter and blocks the next two instruction-cycle
    //   increments. The prescaler keeps running during the block, so software
    //   that wants an exact interval writes a value adjusted by two.
    //
    // Overflow:
    //   A step from FFh to 00h sets the overflow flag and the overflow event.
    //   Hardware never clears the flag; a write from software does. When a
    //   set and a software clear fall in one cycle the set wins, so no
    //   overflow is lost.
    //   The overflow request output is the flag masked by the enable bit.
    //   The event status clears on any accepted read of its word.
    //
    // Sleep:
    //   Sleep freezes the counter, its prescaler input and the sampler, so no
    //   overflow can happen while asleep. The watchdog side keeps running.
    //
    // Hazards:
    //   Changing the option word moves the prescaler tap; the tap history is
    //   reset on that write so the move is never taken for a carry.
    //   The sampler resets to the idle level that the reset option word gives
    //   a low pin, so leaving reset never looks like a counted edge.
    //   The pin is taken as synchronous to the clock; an asynchronous source
    //   needs an outside synchroniser.

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Register index from a byte address; zero for misaligned or out of range
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] word;
        word = addr >> 2;
        if (addr[1:0] != 2'h0 || word > ADDR_W'(8'hFF)) begin
            reg_index = 8'h00;
        end else begin
            reg_index = word[7:0];
        end
    endfunction : reg_index

    // Prescaler output bit for a ratio, offset by one for the watchdog
    function automatic logic prescale_tap(input logic [7:0] pre, input logic [2:0] ratio,
                                          input logic for_wdt);
        logic [2:0] sel;
        sel = ratio - 3'(for_wdt);
        prescale_tap = pre[sel];
    endfunction : prescale_tap

    ////////////////////////////////////////////////////////////////////////////////
    // State

    t0ps_pkg::t0ps_state_t s_q;
    t0ps_pkg::t0ps_state_t s_d;

    logic       req;
    logic       commit;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic       instr_end;
    logic       timer_owns;
    logic       ext_lvl;
    logic       ext_edge;
    logic       pre_event;
    logic       tap;
    logic       tap_fall;
    logic       sync_src;
    logic       ext_tick;
    logic       tick;
    logic       overflow;
    logic       count_wr;
    logic [31:0] rd_val;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait state, commit on the accepting edge

    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~s_q.ack;
    assign commit            = req & s_q.ack;
    assign wr_en             = commit & i_avs_write & i_avs_byteenable[0];
    assign rd_en             = commit & i_avs_read;
    assign idx               = reg_index(i_avs_address);
    assign wbyte             = i_avs_writedata[7:0];
    assign count_wr          = wr_en & (idx == t0ps_pkg::IDX_COUNT);

    // Prescaler never appears on the read path
    always_comb begin
        rd_val = 32'h0000_0000;
        case (idx)
            t0ps_pkg::IDX_COUNT:    rd_val[7:0] = s_q.timer0_count;
            t0ps_pkg::IDX_INTCTL:   rd_val[7:0] = s_q.interrupt_control;
            t0ps_pkg::IDX_OPTION:   rd_val[7:0] = s_q.option_config;
            t0ps_pkg::IDX_EVT_STAT: rd_val[1:0] = s_q.evt_status;
            t0ps_pkg::IDX_EVT_MASK: rd_val[1:0] = s_q.evt_mask;
            default:                rd_val      = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Count path

    assign instr_end  = (s_q.phase == t0ps_pkg::T0PS_Q4);
    assign timer_owns = ~s_q.option_config.prescaler_assign;
    // Inverting the pin makes the counted edge a rise
    assign ext_lvl    = i_ext_count_input ^ s_q.option_config.count_edge_sel;
    assign ext_edge   = ext_lvl & ~s_q.ext_prev;

    always_comb begin
        if (timer_owns) begin
            pre_event = ~i_sleep & (s_q.option_config.count_source_sel ? ext_edge : instr_end);
        end else begin
            pre_event = i_wdt_tick;
        end
    end

    // Counter taps bit N, watchdog bit N-1
    assign tap      = prescale_tap(s_q.prescaler, s_q.option_config.prescale_ratio, ~timer_owns);
    // Carry out of the tapped stage: a full period after a clear
    assign tap_fall = ~tap & s_q.tap_prev;

    // Without prescaler the pin goes straight to the sampler
    assign sync_src = timer_owns ? s_q.prescaler[s_q.option_config.prescale_ratio] : ext_lvl;
    // Rise seen once per instruction after the Q4 sample
    assign ext_tick = instr_end & s_q.sync_q4 & ~s_q.sync_prev;

    always_comb begin
        if (s_q.option_config.count_source_sel) begin
            tick = ext_tick;
        end else if (timer_owns) begin
            tick = tap_fall;
        end else begin
            tick = instr_end;
        end
        // Stopped while asleep; stopped while inhibited
        if (i_sleep || s_q.inhibit != 2'h0) begin
            tick = 1'b0;
        end
    end

    // Wrap from FFh is the overflow event
    assign overflow = tick & (s_q.timer0_count == 8'hFF);

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d = s_q;

        // Instruction phase sequencer
        case (s_q.phase)
            t0ps_pkg::T0PS_Q1: s_d.phase = t0ps_pkg::T0PS_Q2;
            t0ps_pkg::T0PS_Q2: s_d.phase = t0ps_pkg::T0PS_Q3;
            t0ps_pkg::T0PS_Q3: s_d.phase = t0ps_pkg::T0PS_Q4;
            t0ps_pkg::T0PS_Q4: s_d.phase = t0ps_pkg::T0PS_Q1;
            default:           s_d.phase = t0ps_pkg::T0PS_Q1;
        endcase

        s_d.ext_prev = ext_lvl;
        s_d.tap_prev = tap;

        // Sample at Q2, resample at Q4
        if (s_q.phase == t0ps_pkg::T0PS_Q2 && !i_sleep) begin
            s_d.sync_q2 = sync_src;
        end
        if (instr_end && !i_sleep) begin
            s_d.sync_q4   = s_q.sync_q2;
            s_d.sync_prev = s_q.sync_q4;
        end

        // Prescaler
        if (pre_event) begin
            s_d.prescaler = s_q.prescaler + 8'h01;
        end
        // Count write clears the counter-owned prescaler
        if (count_wr && timer_owns) begin
            s_d.prescaler = 8'h00;
            s_d.tap_prev  = 1'b0;
        end
        // Watchdog clear zeroes its prescaler too
        if (i_watchdog_clear_instr && !timer_owns) begin
            s_d.prescaler = 8'h00;
            s_d.tap_prev  = 1'b0;
        end
        s_d.wdt_clear = i_watchdog_clear_instr;

        // Watchdog tick, prescaled only when it owns the prescaler
        if (timer_owns || s_q.option_config.prescale_ratio == 3'h0) begin
            s_d.wdt_tick = i_wdt_tick;
        end else begin
            s_d.wdt_tick = tap_fall;
        end

        if (instr_end && s_q.inhibit != 2'h0) begin
            s_d.inhibit = s_q.inhibit - 2'h1;
        end

        if (tick) begin
            s_d.timer0_count = s_q.timer0_count + 8'h01;
        end

        // Register writes
        if (count_wr) begin
            s_d.timer0_count = wbyte;
            s_d.inhibit      = t0ps_pkg::WRITE_INHIBIT_INSTR;
        end
        if (wr_en) begin
            case (idx)
                t0ps_pkg::IDX_INTCTL:   s_d.interrupt_control = wbyte;
                t0ps_pkg::IDX_OPTION: begin
                    s_d.option_config = wbyte;
                    // A moved tap must not look like a carry
                    s_d.tap_prev      = 1'b0;
                end
                t0ps_pkg::IDX_EVT_MASK: s_d.evt_mask          = wbyte[1:0];
                default:                ;
            endcase
        end

        // Reading the event status clears it
        if (rd_en && idx == t0ps_pkg::IDX_EVT_STAT) begin
            s_d.evt_status = 2'h0;
        end

        // Overflow sets the flag; set beats a same-cycle clear
        // Hardware never clears it, only software writes do
        if (overflow) begin
            s_d.interrupt_control[t0ps_pkg::INT_FLAG_BIT] = 1'b1;
            s_d.evt_status[t0ps_pkg::EVT_OVF_BIT]         = 1'b1;
        end
        if (s_d.wdt_tick) begin
            s_d.evt_status[t0ps_pkg::EVT_WDT_BIT] = 1'b1;
        end

        // Bus acknowledge and read data
        s_d.ack = req & ~s_q.ack;
        if (req && !s_q.ack) begin
            s_d.rdata = rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s_q                   <= '0;
            s_q.phase             <= t0ps_pkg::T0PS_Q1;
            s_q.timer0_count      <= t0ps_pkg::COUNT_RST;
            s_q.interrupt_control <= t0ps_pkg::INTCTL_RST;
            s_q.option_config     <= t0ps_pkg::OPTION_RST;
            s_q.evt_status        <= t0ps_pkg::EVT_RST;
            s_q.evt_mask          <= t0ps_pkg::EVT_RST;
            // Idle level of a low pin under the reset edge setting
            s_q.ext_prev          <= 1'b1;
            s_q.sync_q2           <= 1'b1;
            s_q.sync_q4           <= 1'b1;
            s_q.sync_prev         <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_avs_readdata   = s_q.rdata;
    assign o_wdt_tick       = s_q.wdt_tick;
    assign o_watchdog_clear = s_q.wdt_clear;
    // Enable bit masks the overflow request
    assign o_overflow_irq   = s_q.interrupt_control[t0ps_pkg::INT_EN_BIT]
                            & s_q.interrupt_control[t0ps_pkg::INT_FLAG_BIT];
    assign o_irq            = |(s_q.evt_status & s_q.evt_mask);

endmodule : t0ps_timer0

// File: dv/t0ps_pulse_src.sv
// External pulse source model driving the count pin
`timescale 1ns/100ps
module t0ps_pulse_src (
    input  wire logic i_clk,
    output logic      o_pin
);
    initial o_pin = 1'b0;

    // Each level is held at least 8 clocks so the two-phase sampler sees it
    task automatic edges(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge i_clk);
            o_pin <= ~o_pin;
        end
    endtask : edges
endmodule : t0ps_pulse_src

// File: dv/t0ps_timer0_chk.sv
// Port-level checker for the timer0 block
`timescale 1ns/100ps
module t0ps_chk #(
    parameter int unsigned ADDR_W = 10
) (
    input wire logic              i_clk,
    input wire logic              i_reset_n,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic              i_avs_read,
    input wire logic              i_avs_write,
    input wire logic [31:0]       o_avs_readdata,
    input wire logic              o_avs_waitrequest,
    input wire logic              i_sleep,
    input wire logic              i_wdt_tick,
    input wire logic              i_watchdog_clear_instr,
    input wire logic              o_wdt_tick,
    input wire logic              o_watchdog_clear,
    input wire logic              o_overflow_irq,
    input wire logic              o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wire logic req = i_avs_read || i_avs_write;
    ////////////////////////////////////////
    property p_wait; $rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("wait state wrong");
    property p_upper; i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_unmap; i_avs_read && !o_avs_waitrequest
        && !(i_avs_address[9:2] inside {8'h01, 8'h0B, 8'h81, 8'h90, 8'h91})
        |-> o_avs_readdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_wclr; i_watchdog_clear_instr |=> o_watchdog_clear; endproperty
    a_wclr: assert property (p_wclr) else $error("watchdog clear lost");
    property p_wsrc; o_wdt_tick |-> $past(i_wdt_tick) || $past(i_wdt_tick, 2); endproperty
    a_wsrc: assert property (p_wsrc) else $error("tick without source");
    property p_sleep; $rose(o_overflow_irq) |-> !$past(i_sleep) || $past(i_avs_write); endproperty
    a_sleep: assert property (p_sleep) else $error("overflow while asleep");
    property p_hold; $fell(o_overflow_irq) |-> $past(i_avs_write); endproperty
    a_hold: assert property (p_hold) else $error("flag cleared by hardware");
    property p_irqc; $fell(o_irq) |-> $past(req); endproperty
    a_irqc: assert property (p_irqc) else $error("irq dropped without access");
    c_ovf: cover property ($rose(o_overflow_irq));
    c_irq: cover property ($fell(o_irq));
    c_tick: cover property (o_wdt_tick);
endmodule : t0ps_chk

bind t0ps_timer0 t0ps_chk #(.ADDR_W(ADDR_W)) i_t0ps_chk (.*);

// File: dv/t0ps_timer0_bench.sv
// Self-checking bench for the timer0 block
`timescale 1ns/100ps
module t0ps_timer0_bench;
    localparam logic [7:0] C = t0ps_pkg::IDX_COUNT;
    localparam logic [7:0] I = t0ps_pkg::IDX_INTCTL;
    localparam logic [7:0] O = t0ps_pkg::IDX_OPTION;
    localparam logic [7:0] S = t0ps_pkg::IDX_EVT_STAT;
    localparam logic [7:0] M = t0ps_pkg::IDX_EVT_MASK;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic        sleep = 1'b0;
    logic        tick = 1'b0;
    logic        wclr = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        waitreq, pin, wdt_o, wclr_o, ovf_irq, irq;
    int          miscompares = 0;
    int          checks = 0;
    int          ticks = 0;

    always #25 clk = ~clk;
    always @(posedge clk) if (wdt_o === 1'b1) ticks <= ticks + 1;

    t0ps_timer0 i_t0ps_timer0 (.i_clk(clk), .i_reset_n(rst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdat), .o_avs_waitrequest(waitreq), .i_ext_count_input(pin),
        .i_sleep(sleep), .i_wdt_tick(tick), .i_watchdog_clear_instr(wclr), .o_wdt_tick(wdt_o),
        .o_watchdog_clear(wclr_o), .o_overflow_irq(ovf_irq), .o_irq(irq));
    t0ps_pulse_src i_t0ps_pulse_src (.i_clk(clk), .o_pin(pin));
    ////////////////////////////////////////
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge clk);
        adr  <= {idx, 2'h0};
        wdat <= {24'h0, d};
        wr   <= w;
        rd   <= !w;
        // Read right after the edge: the values the design sampled there
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdat[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rchk(input string n, input logic [7:0] idx, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(n, e, q);
    endtask : rchk

    task automatic wrt(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask : wrt

    task automatic pl(input logic w);
        @(posedge clk);
        wclr <= w;
        tick <= !w;
        @(posedge clk);
        wclr <= 1'b0;
        tick <= 1'b0;
    endtask : pl

    task automatic end_sim;
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim();
    end

    initial begin
        logic [7:0] a, b;
        int n;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rchk("count", C, 8'h00);
        rchk("intctl", I, 8'h00);
        rchk("option", O, 8'hFF);
        rchk("status", S, 8'h00);
        rchk("mask", M, 8'h00);
        wrt(8'h55, 8'hAA);
        rchk("unmapped", 8'h55, 8'h00);
        wrt(O, 8'hC8);
        wrt(C, 8'h50);
        rchk("inhibit", C, 8'h50);
        rchk("inhibit", C, 8'h50);
        bus(1'b0, C, 8'h00, a);
        repeat (37) @(posedge clk);
        bus(1'b0, C, 8'h00, b);
        chk("rate", a + 8'h0A, b);
        // Two increments per window of two prescaled periods
        for (int r = 0; r < 8; r++) begin
            wrt(O, {5'h00, r[2:0]});
            bus(1'b0, C, 8'h00, a);
            repeat ((16 << r) - 3) @(posedge clk);
            bus(1'b0, C, 8'h00, b);
            chk("ratio", a + 8'h02, b);
        end
        wrt(C, 8'h00);
        repeat (1000) @(posedge clk);
        rchk("psc_clear", C, 8'h00);
        wrt(O, 8'hC9);
        n = ticks;
        repeat (4) pl(1'b0);
        repeat (3) @(posedge clk);
        chk("wdt_div", n + 2, ticks);
        n = ticks;
        pl(1'b1);
        pl(1'b0);
        pl(1'b1);
        pl(1'b0);
        repeat (3) @(posedge clk);
        chk("wdt_clr", n, ticks);
        wrt(O, 8'hC1);
        n = ticks;
        repeat (2) pl(1'b0);
        repeat (3) @(posedge clk);
        chk("wdt_bypass", n + 2, ticks);
        // Pin starts low: five toggles give three rises, then three give two falls
        wrt(O, 8'hE8);
        wrt(C, 8'h00);
        repeat (12) @(posedge clk);
        i_t0ps_pulse_src.edges(5, 8);
        repeat (12) @(posedge clk);
        rchk("rising", C, 8'h03);
        wrt(O, 8'hF8);
        wrt(C, 8'h00);
        repeat (12) @(posedge clk);
        i_t0ps_pulse_src.edges(3, 8);
        repeat (12) @(posedge clk);
        rchk("falling", C, 8'h02);
        wrt(O, 8'hC8);
        sleep <= 1'b1;
        bus(1'b0, C, 8'h00, a);
        repeat (37) @(posedge clk);
        bus(1'b0, C, 8'h00, b);
        chk("sleep", a, b);
        sleep <= 1'b0;
        bus(1'b0, S, 8'h00, a);
        wrt(I, 8'h00);
        wrt(C, 8'hFE);
        repeat (30) @(posedge clk);
        chk("ovf_irq", 8'h00, {7'h00, ovf_irq});
        chk("irq", 8'h00, {7'h00, irq});
        rchk("flag", I, 8'h04);
        wrt(M, 8'h01);
        @(negedge clk);
        chk("irq", 8'h01, {7'h00, irq});
        wrt(I, 8'h24);
        @(negedge clk);
        chk("ovf_irq", 8'h01, {7'h00, ovf_irq});
        rchk("status", S, 8'h01);
        @(negedge clk);
        chk("irq", 8'h00, {7'h00, irq});
        repeat (200) @(posedge clk);
        rchk("sticky", I, 8'h24);
        wrt(I, 8'h20);
        @(negedge clk);
        chk("ovf_irq", 8'h00, {7'h00, ovf_irq});
        end_sim();
    end
endmodule : t0ps_timer0_bench
